// [spgp_pkg.sv]
package spgp_pkg;

  localparam int SPGP_ADDR_W  = 24;
  localparam int SPGP_DATA_W  = 24;
  localparam int SPGP_PIN_MAX = 6;
  localparam int SPGP_NPORT   = 3;

  // port numbers inside the register file
  localparam logic [1:0] SPGP_PORT_C = 2'h0;
  localparam logic [1:0] SPGP_PORT_D = 2'h1;
  localparam logic [1:0] SPGP_PORT_E = 2'h2;

  // pin counts per port
  localparam int SPGP_PC_PINS = 6;
  localparam int SPGP_PD_PINS = 6;
  localparam int SPGP_PE_PINS = 3;

  // implemented pin bits per port
  localparam logic [5:0] SPGP_PC_MASK = 6'h3f;
  localparam logic [5:0] SPGP_PD_MASK = 6'h3f;
  localparam logic [5:0] SPGP_PE_MASK = 6'h07;

  // register offsets
  localparam logic [23:0] SPGP_PC_FSEL_OFF = 24'hff_ffbf;
  localparam logic [23:0] SPGP_PC_DIR_OFF  = 24'hff_ffbe;
  localparam logic [23:0] SPGP_PC_DATA_OFF = 24'hff_ffbd;
  localparam logic [23:0] SPGP_PD_FSEL_OFF = 24'hff_ffaf;
  localparam logic [23:0] SPGP_PD_DIR_OFF  = 24'hff_ffae;
  localparam logic [23:0] SPGP_PD_DATA_OFF = 24'hff_ffad;
  localparam logic [23:0] SPGP_PE_FSEL_OFF = 24'hff_ff9f;
  localparam logic [23:0] SPGP_PE_DIR_OFF  = 24'hff_ff9e;
  localparam logic [23:0] SPGP_PE_DATA_OFF = 24'hff_ff9d;

  // values after reset
  localparam logic [5:0]  SPGP_FSEL_RST  = 6'h00;
  localparam logic [5:0]  SPGP_DIR_RST   = 6'h00;
  localparam logic [5:0]  SPGP_DATA_RST  = 6'h00;
  localparam logic [5:0]  SPGP_SYNC_RST  = 6'h00;
  localparam logic [23:0] SPGP_RDATA_RST = 24'h00_0000;
  localparam logic [17:0] SPGP_RSVD_ZERO = 18'h0_0000;

  typedef enum logic [1:0] {
    SPGP_FLD_DATA = 2'h0,
    SPGP_FLD_DIR  = 2'h1,
    SPGP_FLD_FSEL = 2'h3
  } spgp_field_t;

  typedef struct packed {
    logic [5:0] fsel;
    logic [5:0] dir;
    logic [5:0] data;
  } spgp_port_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } spgp_bus_req_t;

  typedef struct packed {
    logic        hit;
    logic [1:0]  port;
    spgp_field_t field;
  } spgp_dec_t;

  function automatic spgp_dec_t spgp_decode(input logic [23:0] addr);
    spgp_dec_t d;
    d = '{hit: 1'b1, port: SPGP_PORT_C, field: SPGP_FLD_DATA};
    case (addr)
      SPGP_PC_FSEL_OFF: d = '{hit: 1'b1, port: SPGP_PORT_C, field: SPGP_FLD_FSEL};
      SPGP_PC_DIR_OFF:  d = '{hit: 1'b1, port: SPGP_PORT_C, field: SPGP_FLD_DIR};
      SPGP_PC_DATA_OFF: d = '{hit: 1'b1, port: SPGP_PORT_C, field: SPGP_FLD_DATA};
      SPGP_PD_FSEL_OFF: d = '{hit: 1'b1, port: SPGP_PORT_D, field: SPGP_FLD_FSEL};
      SPGP_PD_DIR_OFF:  d = '{hit: 1'b1, port: SPGP_PORT_D, field: SPGP_FLD_DIR};
      SPGP_PD_DATA_OFF: d = '{hit: 1'b1, port: SPGP_PORT_D, field: SPGP_FLD_DATA};
      SPGP_PE_FSEL_OFF: d = '{hit: 1'b1, port: SPGP_PORT_E, field: SPGP_FLD_FSEL};
      SPGP_PE_DIR_OFF:  d = '{hit: 1'b1, port: SPGP_PORT_E, field: SPGP_FLD_DIR};
      SPGP_PE_DATA_OFF: d = '{hit: 1'b1, port: SPGP_PORT_E, field: SPGP_FLD_DATA};
      default:          d = '{hit: 1'b0, port: SPGP_PORT_C, field: SPGP_FLD_DATA};
    endcase
    return d;
  endfunction

  function automatic logic [5:0] spgp_mask(input logic [1:0] port);
    logic [5:0] m;
    m = 6'h00;
    case (port)
      SPGP_PORT_C: m = SPGP_PC_MASK;
      SPGP_PORT_D: m = SPGP_PD_MASK;
      SPGP_PORT_E: m = SPGP_PE_MASK;
      default:     m = 6'h00;
    endcase
    return m;
  endfunction

endpackage

// [spgp_pin_mux.sv]
`timescale 1ns/10ps
module spgp_pin_mux
  import spgp_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_fsel,
  input  wire logic [W-1:0] i_dir,
  input  wire logic [W-1:0] i_data,
  input  wire logic [W-1:0] i_pin_sync,
  input  wire logic [W-1:0] i_per_out,
  input  wire logic [W-1:0] i_per_oe,
  output logic      [W-1:0] o_pin,
  output logic      [W-1:0] o_pin_oe,
  output logic      [W-1:0] o_per_in
);

  logic [W-1:0] pin_reg;
  logic [W-1:0] pin_next;
  logic [W-1:0] oe_reg;
  logic [W-1:0] oe_next;
  logic [W-1:0] per_in_reg;
  logic [W-1:0] per_in_next;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (i_fsel[i]) begin
        // pin handed to its serial peripheral
        pin_next[i]    = i_per_out[i]; // [RQ1]
        oe_next[i]     = i_per_oe[i]; // [RQ1]
        per_in_next[i] = i_pin_sync[i]; // [RQ1]
      end else begin
        pin_next[i]    = i_data[i]; // [RQ4]
        oe_next[i]     = i_dir[i]; // [RQ2]
        per_in_next[i] = 1'b0; // [RQ1]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_reg    <= '0;
      oe_reg     <= '0;
      per_in_reg <= '0;
    end else begin
      pin_reg    <= pin_next;
      oe_reg     <= oe_next;
      per_in_reg <= per_in_next;
    end
  end

  assign o_pin    = pin_reg;
  assign o_pin_oe = oe_reg;
  assign o_per_in = per_in_reg;

endmodule

// [spgp_top.sv]
// Contract
// [RQ1] A pin whose function-select bit is 1 belongs to its serial peripheral, with 0 it is GPIO.
// [RQ2] A GPIO pin is driven when its direction bit is 1 and left undriven as input when 0.
// [RQ3] Reading the data bit of a GPIO input pin returns the level present on that pin.
// [RQ4] A GPIO output pin drives the value last written to its data bit.
// [RQ5] Reset clears function-select, direction and data of port C, so all its pins are inputs.
// [RQ6] Reset clears the function-select register of port D, so all its pins are GPIO.
// [RQ7] Software writes zero to every reserved bit above the implemented pin bits.
// [RQ8] Ports C and D implement pin bits 0 to 5, port E implements pin bits 0 to 2.
// [RQ9] Reserved and unimplemented bits read as zero and ignore writes.
`timescale 1ns/10ps
module spgp_top
  import spgp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [23:0] o_rdata,
  input  wire logic [5:0]  i_pc_pin,
  output logic      [5:0]  o_pc_pin,
  output logic      [5:0]  o_pc_pin_oe,
  input  wire logic [5:0]  i_pc_per_out,
  input  wire logic [5:0]  i_pc_per_oe,
  output logic      [5:0]  o_pc_per_in,
  input  wire logic [5:0]  i_pd_pin,
  output logic      [5:0]  o_pd_pin,
  output logic      [5:0]  o_pd_pin_oe,
  input  wire logic [5:0]  i_pd_per_out,
  input  wire logic [5:0]  i_pd_per_oe,
  output logic      [5:0]  o_pd_per_in,
  input  wire logic [2:0]  i_pe_pin,
  output logic      [2:0]  o_pe_pin,
  output logic      [2:0]  o_pe_pin_oe,
  input  wire logic [2:0]  i_pe_per_out,
  input  wire logic [2:0]  i_pe_per_oe,
  output logic      [2:0]  o_pe_per_in
);

  spgp_bus_req_t             req;
  spgp_dec_t                 dec;
  spgp_port_t [2:0]          port_reg;
  spgp_port_t [2:0]          port_next;
  logic       [2:0][5:0]     pin_raw;
  logic       [2:0][5:0]     sync1_reg;
  logic       [2:0][5:0]     sync2_reg;
  logic       [23:0]         rdata_reg;
  logic       [23:0]         rdata_next;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign dec = spgp_decode(req.addr);

  assign pin_raw[SPGP_PORT_C] = i_pc_pin;
  assign pin_raw[SPGP_PORT_D] = i_pd_pin;
  assign pin_raw[SPGP_PORT_E] = {3'h0, i_pe_pin};

  // two-stage pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < SPGP_NPORT; p++) begin
        sync1_reg[p] <= SPGP_SYNC_RST;
        sync2_reg[p] <= SPGP_SYNC_RST;
      end
    end else begin
      for (int p = 0; p < SPGP_NPORT; p++) begin
        sync1_reg[p] <= pin_raw[p];
        sync2_reg[p] <= sync1_reg[p];
      end
    end
  end

  // data bit as software sees it: latch for GPIO outputs, pin level for GPIO inputs and peripheral pins
  function automatic logic [5:0] spgp_data_view(input spgp_port_t pr,
                                                input logic [5:0] pin,
                                                input logic [5:0] mask);
    logic [5:0] drv;
    drv = pr.dir & ~pr.fsel;
    return ((pr.data & drv) | (pin & ~drv)) & mask;
  endfunction

  // register write path
  always_comb begin
    port_next = port_reg;
    if (req.wr && dec.hit) begin
      case (dec.field)
        SPGP_FLD_FSEL: port_next[dec.port].fsel = req.wdata[5:0] & spgp_mask(dec.port); // [RQ8]
        SPGP_FLD_DIR:  port_next[dec.port].dir  = req.wdata[5:0] & spgp_mask(dec.port); // [RQ8]
        SPGP_FLD_DATA: port_next[dec.port].data = req.wdata[5:0] & spgp_mask(dec.port); // [RQ4]
        default:       port_next = port_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int p = 0; p < SPGP_NPORT; p++) begin
        port_reg[p].fsel <= SPGP_FSEL_RST; // [RQ5] [RQ6]
        port_reg[p].dir  <= SPGP_DIR_RST; // [RQ5]
        port_reg[p].data <= SPGP_DATA_RST; // [RQ5]
      end
    end else begin
      port_reg <= port_next;
    end
  end

  // register read path, answer in the next cycle only
  always_comb begin
    rdata_next = SPGP_RDATA_RST;
    if (req.rd && dec.hit) begin
      case (dec.field)
        SPGP_FLD_FSEL: rdata_next = {SPGP_RSVD_ZERO, port_reg[dec.port].fsel}; // [RQ9]
        SPGP_FLD_DIR:  rdata_next = {SPGP_RSVD_ZERO, port_reg[dec.port].dir}; // [RQ9]
        SPGP_FLD_DATA: rdata_next = {SPGP_RSVD_ZERO,
                                     spgp_data_view(port_reg[dec.port],
                                                    sync2_reg[dec.port],
                                                    spgp_mask(dec.port))}; // [RQ3]
        default:       rdata_next = SPGP_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= SPGP_RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  spgp_pin_mux #(
    .W (SPGP_PC_PINS)
  ) u_port_c (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_fsel     (port_reg[SPGP_PORT_C].fsel),
    .i_dir      (port_reg[SPGP_PORT_C].dir),
    .i_data     (port_reg[SPGP_PORT_C].data),
    .i_pin_sync (sync2_reg[SPGP_PORT_C]),
    .i_per_out  (i_pc_per_out),
    .i_per_oe   (i_pc_per_oe),
    .o_pin      (o_pc_pin),
    .o_pin_oe   (o_pc_pin_oe),
    .o_per_in   (o_pc_per_in)
  );

  spgp_pin_mux #(
    .W (SPGP_PD_PINS)
  ) u_port_d (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_fsel     (port_reg[SPGP_PORT_D].fsel),
    .i_dir      (port_reg[SPGP_PORT_D].dir),
    .i_data     (port_reg[SPGP_PORT_D].data),
    .i_pin_sync (sync2_reg[SPGP_PORT_D]),
    .i_per_out  (i_pd_per_out),
    .i_per_oe   (i_pd_per_oe),
    .o_pin      (o_pd_pin),
    .o_pin_oe   (o_pd_pin_oe),
    .o_per_in   (o_pd_per_in)
  );

  spgp_pin_mux #(
    .W (SPGP_PE_PINS)
  ) u_port_e (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_fsel     (port_reg[SPGP_PORT_E].fsel[2:0]),
    .i_dir      (port_reg[SPGP_PORT_E].dir[2:0]),
    .i_data     (port_reg[SPGP_PORT_E].data[2:0]),
    .i_pin_sync (sync2_reg[SPGP_PORT_E][2:0]),
    .i_per_out  (i_pe_per_out),
    .i_per_oe   (i_pe_per_oe),
    .o_pin      (o_pe_pin),
    .o_pin_oe   (o_pe_pin_oe),
    .o_per_in   (o_pe_per_in)
  );

endmodule

// [spgp_top_sva.sv]
`timescale 1ns/10ps
module spgp_top_sva
  import spgp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [23:0] i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [23:0] o_rdata,
  input  wire logic [5:0]  i_pc_pin,
  input  wire logic [5:0]  o_pc_pin,
  input  wire logic [5:0]  o_pc_pin_oe,
  input  wire logic [5:0]  i_pc_per_out,
  input  wire logic [5:0]  i_pc_per_oe,
  input  wire logic [5:0]  o_pc_per_in
);
  logic [5:0] fs_reg, dr_reg, dt_reg, oe_x, pv_x, gout;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // shadow of the port c registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {fs_reg, dr_reg, dt_reg} <= '0;
    end else if (i_wr) begin
      if (i_addr == SPGP_PC_FSEL_OFF) fs_reg <= i_wdata[5:0];
      if (i_addr == SPGP_PC_DIR_OFF) dr_reg <= i_wdata[5:0];
      if (i_addr == SPGP_PC_DATA_OFF) dt_reg <= i_wdata[5:0];
    end
  end
  assign oe_x = (fs_reg & i_pc_per_oe) | (~fs_reg & dr_reg);
  assign pv_x = (fs_reg & i_pc_per_out) | (~fs_reg & dt_reg);
  assign gout = dr_reg & ~fs_reg;
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  a_pin_enable: assert property (o_pc_pin_oe == $past(oe_x))
    else $error("pin enable wrong");
  a_pin_value: assert property (
    (o_pc_pin & $past(oe_x)) == ($past(pv_x) & $past(oe_x)))
    else $error("pin value wrong");
  a_per_gated: assert property ((o_pc_per_in & ~$past(fs_reg)) == 6'h00)
    else $error("peripheral sees gpio pin");
  a_per_follow: assert property ((o_pc_per_in & $past(fs_reg)) ==
    ($past(i_pc_pin, 3) & $past(fs_reg)))
    else $error("peripheral input wrong");
  a_data_read: assert property (s_rd(SPGP_PC_DATA_OFF) |=> o_rdata ==
    {SPGP_RSVD_ZERO, ($past(gout) & $past(dt_reg)) | (~$past(gout) & $past(i_pc_pin, 3))})
    else $error("data read wrong");
  a_ctrl_read: assert property (s_rd(SPGP_PC_FSEL_OFF) |=>
    o_rdata == {SPGP_RSVD_ZERO, $past(fs_reg)})
    else $error("select read wrong");
  a_unmapped_zero: assert property (s_rd(24'hff_ffbc) |=> o_rdata == 24'h00_0000)
    else $error("unmapped read not zero");
  a_pe_reserved: assert property (s_rd(SPGP_PE_DATA_OFF) |=> o_rdata[23:3] == 21'h00_0000)
    else $error("port e reserved bits set");
endmodule

// [spgp_board.sv]
`timescale 1ns/10ps
module spgp_board #(
  parameter int W = 6
) (
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_ext,
  output logic      [W-1:0] o_lvl
);
  // board drives only pins the device leaves released
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// [spgp_top_tb.sv]
`timescale 1ns/10ps
module spgp_top_tb
  import spgp_pkg::*;
;
  localparam logic [23:0] CTL [6] = '{SPGP_PC_FSEL_OFF, SPGP_PC_DIR_OFF, SPGP_PD_FSEL_OFF,
    SPGP_PD_DIR_OFF, SPGP_PE_FSEL_OFF, SPGP_PE_DIR_OFF};
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [23:0] i_addr = '0;
  logic [23:0] i_wdata = '0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [23:0] o_rdata, q;
  logic [5:0]  ext_c = 6'h15, ext_d = 6'h2a, per_out = '0, per_oe = '0;
  logic [5:0]  pc_lvl, o_pc_pin, o_pc_pin_oe, o_pc_per_in, pd_lvl, o_pd_pin, o_pd_pin_oe;
  logic [5:0]  o_pd_per_in;
  logic [2:0]  pe_lvl, o_pe_pin, o_pe_pin_oe, o_pe_per_in;
  int          error_cnt = 0, check_count = 0, cyc = 0;
  spgp_top spgp_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pc_pin(pc_lvl),
    .o_pc_pin(o_pc_pin), .o_pc_pin_oe(o_pc_pin_oe), .i_pc_per_out(per_out),
    .i_pc_per_oe(per_oe), .o_pc_per_in(o_pc_per_in), .i_pd_pin(pd_lvl), .o_pd_pin(o_pd_pin),
    .o_pd_pin_oe(o_pd_pin_oe), .i_pd_per_out(per_out), .i_pd_per_oe(per_oe),
    .o_pd_per_in(o_pd_per_in), .i_pe_pin(pe_lvl), .o_pe_pin(o_pe_pin),
    .o_pe_pin_oe(o_pe_pin_oe), .i_pe_per_out(per_out[2:0]), .i_pe_per_oe(per_oe[2:0]),
    .o_pe_per_in(o_pe_per_in));
  spgp_board #(.W(6)) spgp_board_c_inst (.i_oe(o_pc_pin_oe), .i_out(o_pc_pin),
    .i_ext(ext_c), .o_lvl(pc_lvl));
  spgp_board #(.W(6)) spgp_board_d_inst (.i_oe(o_pd_pin_oe), .i_out(o_pd_pin),
    .i_ext(ext_d), .o_lvl(pd_lvl));
  spgp_board #(.W(3)) spgp_board_e_inst (.i_oe(o_pe_pin_oe), .i_out(o_pe_pin),
    .i_ext(ext_c[2:0]), .o_lvl(pe_lvl));
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [23:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask
  task automatic t_regs();
    foreach (CTL[i]) begin
      rd(CTL[i]);
      chk("ctrl reset", q, 24'h00_0000);
      wr(CTL[i], 24'h00_003f);
      rd(CTL[i]);
      chk("ctrl mask", q, (i < 4) ? 24'h00_003f : 24'h00_0007);
      wr(CTL[i], 24'h00_0000);
    end
    wr(24'hff_ffbc, 24'hff_ffff);
    rd(24'hff_ffbc);
    chk("unmapped", q, 24'h00_0000);
    $display("test regs done");
  endtask
  task automatic t_out();
    wr(SPGP_PC_DIR_OFF, 24'h00_003f);
    repeat (2) @(posedge i_clk);
    #1 chk("pc oe", 24'(o_pc_pin_oe), 24'h00_003f);
    chk("pc pin reset", 24'(o_pc_pin), 24'h00_0000);
    wr(SPGP_PC_DATA_OFF, 24'h00_002a);
    repeat (2) @(posedge i_clk);
    #1 chk("pc pin", 24'(o_pc_pin), 24'h00_002a);
    rd(SPGP_PC_DATA_OFF);
    chk("pc data", q, 24'h00_002a);
    wr(SPGP_PE_DIR_OFF, 24'h00_0007);
    wr(SPGP_PE_DATA_OFF, 24'h00_0005);
    wr(SPGP_PD_DIR_OFF, 24'h00_0030);
    wr(SPGP_PD_DATA_OFF, 24'h00_0010);
    repeat (2) @(posedge i_clk);
    #1 chk("pe pin", 24'({o_pe_pin_oe, o_pe_pin}), 24'h00_003d);
    chk("pd pin", 24'({o_pd_pin_oe, o_pd_pin}), 24'h00_0c10);
    rd(SPGP_PE_DATA_OFF);
    chk("pe data", q, 24'h00_0005);
    $display("test out done");
  endtask
  task automatic t_in();
    wr(SPGP_PC_DIR_OFF, 24'h00_0000);
    ext_c <= 6'h0b;
    repeat (3) @(posedge i_clk);
    rd(SPGP_PC_DATA_OFF);
    chk("pc input", q, 24'h00_000b);
    chk("pc released", 24'({o_pc_pin_oe, o_pc_per_in}), 24'h00_0000);
    rd(SPGP_PD_DATA_OFF);
    chk("pd input", q, 24'h00_001a);
    chk("pd released", 24'(o_pd_per_in), 24'h00_0000);
    $display("test in done");
  endtask
  task automatic t_per();
    @(posedge i_clk);
    per_oe <= 6'h0f;
    per_out <= 6'h05;
    ext_c <= 6'h3b;
    wr(SPGP_PC_FSEL_OFF, 24'h00_003f);
    wr(SPGP_PD_FSEL_OFF, 24'h00_003f);
    wr(SPGP_PE_FSEL_OFF, 24'h00_0007);
    repeat (5) @(posedge i_clk);
    #1 chk("per oe", 24'(o_pc_pin_oe), 24'h00_000f);
    chk("per pin", 24'(o_pc_pin & 6'h0f), 24'h00_0005);
    chk("per in", 24'(o_pc_per_in), 24'h00_0035);
    chk("pd per", 24'({o_pd_pin_oe, o_pd_per_in}), 24'h00_03e5);
    chk("pe per", 24'({o_pe_pin_oe, o_pe_per_in}), 24'h00_003d);
    $display("test peripheral done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_out();
    t_in();
    t_per();
    summarize();
  end
endmodule
bind spgp_top spgp_top_sva spgp_top_sva_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_pc_pin(i_pc_pin), .o_pc_pin(o_pc_pin), .o_pc_pin_oe(o_pc_pin_oe),
  .i_pc_per_out(i_pc_per_out), .i_pc_per_oe(i_pc_per_oe), .o_pc_per_in(o_pc_per_in));
